/* pkg/ctp_pkg.sv */
// Package with register map, field layout, reset values and timing constants of the 16-bit timer.
package ctp_pkg;

  localparam logic [7:0]  ADDR_CMP_LO      = 8'h00;
  localparam logic [7:0]  ADDR_CMP_HI      = 8'h04;
  localparam logic [7:0]  ADDR_DUTY_LO     = 8'h08;
  localparam logic [7:0]  ADDR_DUTY_HI     = 8'h0C;
  localparam logic [7:0]  ADDR_LOWER_CTRL  = 8'h10;
  localparam logic [7:0]  ADDR_UPPER_CTRL  = 8'h14;
  localparam logic [7:0]  ADDR_STATUS      = 8'h18;

  localparam int          LCTRL_MODE_LSB   = 0;
  localparam int          LCTRL_CLK_LSB    = 4;
  localparam int          UCTRL_DIVSEL_BIT = 0;
  localparam int          UCTRL_RUN_BIT    = 3;
  localparam int          UCTRL_FFINIT_BIT = 7;
  localparam int          STAT_FF_BIT      = 16;
  localparam int          STAT_RUN_BIT     = 17;

  localparam logic [2:0]  MODE_TIMER16     = 3'h4;
  localparam logic [2:0]  MODE_EVENT16     = 3'h5;
  localparam logic [2:0]  MODE_PWM16       = 3'h6;

  localparam logic [2:0]  CLK_SLOWEST      = 3'h0;
  localparam logic [2:0]  CLK_FC_DIV7      = 3'h1;
  localparam logic [2:0]  CLK_FC_DIV5      = 3'h2;
  localparam logic [2:0]  CLK_FC_DIV3      = 3'h3;
  localparam logic [2:0]  CLK_FS          = 3'h4;
  localparam logic [2:0]  CLK_FC_DIV1      = 3'h5;
  localparam logic [2:0]  CLK_FC           = 3'h6;
  localparam logic [2:0]  CLK_EXTERNAL     = 3'h7;

  localparam int          FC_DIV_BITS      = 11;
  localparam int          FS_DIV_BITS      = 3;

  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [15:0] CNT_MAX          = 16'hFFFF;
  localparam logic [15:0] CNT_ONE          = 16'h0001;

  typedef enum logic [3:0]
  {
    CTP_IDLE  = 4'b0001,
    CTP_TIMER = 4'b0010,
    CTP_EVENT = 4'b0100,
    CTP_PWM   = 4'b1000
  } ctp_mode_e;

endpackage

/* verilog/ctp_timer16.sv */
// Cascaded 16-bit timer, event counter and PWM generator with an APB register slave.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ctp_timer16
  import ctp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_fs_tick,
  input  wire logic        i_low_speed,
  input  wire logic        i_external_count_input,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_upper_counter_interrupt,
  output logic             o_pwm_out_pin
);

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [7:0]  cmp_lo_ff;
  logic [7:0]  cmp_hi_ff;
  logic [15:0] duty_buf_ff;
  logic [15:0] duty_act_ff;
  logic [7:0]  lower_ctrl_ff;
  logic [7:0]  upper_ctrl_ff;
  logic [15:0] cnt_ff;
  logic        ff_ff;
  logic        irq_ff;
  logic        pin_ff;
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        wr_en;
  logic        run;
  logic [15:0] cmp_val;
  logic [15:0] nxt_duty_buf;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, ADDR_CMP_LO) || hit(addr, ADDR_CMP_HI) || hit(addr, ADDR_DUTY_LO) ||
             hit(addr, ADDR_DUTY_HI) || hit(addr, ADDR_LOWER_CTRL) ||
             hit(addr, ADDR_UPPER_CTRL) || hit(addr, ADDR_STATUS);
  endfunction

  assign wr_en   = i_psel && i_penable && i_pwrite && pready_ff && mapped(i_paddr);
  assign run     = upper_ctrl_ff[UCTRL_RUN_BIT];
  assign cmp_val = {cmp_hi_ff, cmp_lo_ff};

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= i_psel && !i_penable && !pready_ff;
      pslverr_ff <= i_psel && !i_penable && !mapped(i_paddr);
      if (i_psel && !i_penable)
      begin
        prdata_ff <= 32'h0000_0000;
        if (!i_pwrite)
        begin
          unique case (1'b1)
            hit(i_paddr, ADDR_CMP_LO):     prdata_ff[7:0]  <= cmp_lo_ff;
            hit(i_paddr, ADDR_CMP_HI):     prdata_ff[7:0]  <= cmp_hi_ff;
            hit(i_paddr, ADDR_DUTY_LO):    prdata_ff[7:0]  <= duty_act_ff[7:0];
            hit(i_paddr, ADDR_DUTY_HI):    prdata_ff[7:0]  <= duty_act_ff[15:8];
            hit(i_paddr, ADDR_LOWER_CTRL): prdata_ff[7:0]  <= lower_ctrl_ff;
            hit(i_paddr, ADDR_UPPER_CTRL): prdata_ff[7:0]  <= upper_ctrl_ff;
            hit(i_paddr, ADDR_STATUS):
            begin
              prdata_ff[15:0]         <= cnt_ff;
              prdata_ff[STAT_FF_BIT]  <= ff_ff;
              prdata_ff[STAT_RUN_BIT] <= run;
            end
            default:                       prdata_ff       <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Compare and control registers; compare has no buffer stage.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cmp_lo_ff     <= RST_BYTE;
      cmp_hi_ff     <= RST_BYTE;
      lower_ctrl_ff <= RST_BYTE;
      upper_ctrl_ff <= RST_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(i_paddr, ADDR_CMP_LO))     cmp_lo_ff     <= i_pwdata[7:0];
      if (hit(i_paddr, ADDR_CMP_HI))     cmp_hi_ff     <= i_pwdata[7:0];
      if (hit(i_paddr, ADDR_LOWER_CTRL)) lower_ctrl_ff <= i_pwdata[7:0];
      if (hit(i_paddr, ADDR_UPPER_CTRL)) upper_ctrl_ff <= i_pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Mode and source clock selection
  // ----------------------------------------------------------------------
  ctp_mode_e                mode;
  logic [FC_DIV_BITS-1:0]  fc_div_ff;
  logic [FS_DIV_BITS-1:0]  fs_div_ff;
  logic                    ext_prev_ff;
  logic                    ext_fall;
  logic                    tick;
  logic                    slow_tap;
  logic [2:0]              clk_sel;

  always_comb
  begin
    unique case (lower_ctrl_ff[LCTRL_MODE_LSB +: 3])
      MODE_TIMER16: mode = CTP_TIMER;
      MODE_EVENT16: mode = CTP_EVENT;
      MODE_PWM16:   mode = CTP_PWM;
      default:      mode = CTP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fc_div_ff   <= '0;
      fs_div_ff   <= '0;
      ext_prev_ff <= 1'b1;
    end
    else
    begin
      fc_div_ff   <= fc_div_ff + 1'b1;
      ext_prev_ff <= i_external_count_input;
      if (i_fs_tick)
        fs_div_ff <= fs_div_ff + 1'b1;
    end
  end

  assign ext_fall = ext_prev_ff && !i_external_count_input;
  assign clk_sel  = lower_ctrl_ff[LCTRL_CLK_LSB +: 3];
  assign slow_tap = upper_ctrl_ff[UCTRL_DIVSEL_BIT] ? (i_fs_tick && (&fs_div_ff))
                                                    : (&fc_div_ff);

  always_comb
  begin
    tick = 1'b0;
    if (mode == CTP_EVENT)
      tick = ext_fall;
    else if (i_low_speed)
    begin
      if (clk_sel == CLK_SLOWEST)
        tick = i_fs_tick && (&fs_div_ff);
      else if (clk_sel == CLK_FS && mode == CTP_PWM)
        tick = i_fs_tick;
    end
    else
    begin
      unique case (clk_sel)
        CLK_SLOWEST:  tick = slow_tap;
        CLK_FC_DIV7:  tick = &fc_div_ff[6:0];
        CLK_FC_DIV5:  tick = &fc_div_ff[4:0];
        CLK_FC_DIV3:  tick = &fc_div_ff[2:0];
        CLK_FS:       tick = (mode == CTP_PWM) && i_fs_tick;
        CLK_FC_DIV1:  tick = (mode == CTP_PWM) && fc_div_ff[0];
        CLK_FC:       tick = (mode == CTP_PWM);
        CLK_EXTERNAL: tick = (mode == CTP_PWM) && ext_fall;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Counter, output flip-flop and duty buffer
  // ----------------------------------------------------------------------
  logic        upper_wr;
  logic        overflow;
  logic        cmp_match;
  logic        duty_match;
  logic        nxt_ff;
  logic [15:0] cnt_plus;
  logic [7:0]  upper_new;

  assign cnt_plus   = cnt_ff + CNT_ONE;
  assign upper_wr   = wr_en && hit(i_paddr, ADDR_UPPER_CTRL);
  assign upper_new  = i_pwdata[7:0];
  assign overflow   = run && mode == CTP_PWM && tick && cnt_ff == CNT_MAX;
  assign cmp_match  = run && (mode == CTP_TIMER || mode == CTP_EVENT) && tick &&
                      cnt_plus == cmp_val;
  assign duty_match = run && mode == CTP_PWM && tick && !overflow &&
                      cnt_plus == duty_act_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_ff <= RST_WORD;
    else if (!run || mode == CTP_IDLE)
      cnt_ff <= RST_WORD;
    else if (cmp_match || overflow)
      cnt_ff <= RST_WORD;
    else if (tick)
      cnt_ff <= cnt_plus;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= cmp_match || overflow;
  end

  always_comb
  begin
    nxt_ff = ff_ff;
    if (upper_wr && !upper_new[UCTRL_RUN_BIT] && !run)
      nxt_ff = upper_new[UCTRL_FFINIT_BIT];
    else if (upper_wr && upper_new[UCTRL_RUN_BIT] && !run)
      nxt_ff = upper_new[UCTRL_FFINIT_BIT];
    else if (overflow || duty_match)
      nxt_ff = !ff_ff;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ff_ff  <= 1'b0;
      pin_ff <= 1'b1;
    end
    else
    begin
      ff_ff  <= nxt_ff;
      pin_ff <= !nxt_ff;
    end
  end

  always_comb
  begin
    nxt_duty_buf = duty_buf_ff;
    if (wr_en && hit(i_paddr, ADDR_DUTY_LO))
      nxt_duty_buf[7:0] = i_pwdata[7:0];
    if (wr_en && hit(i_paddr, ADDR_DUTY_HI))
      nxt_duty_buf[15:8] = i_pwdata[7:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      duty_buf_ff <= RST_WORD;
      duty_act_ff <= RST_WORD;
    end
    else
    begin
      duty_buf_ff <= nxt_duty_buf;
      if (!run || mode != CTP_PWM)
        duty_act_ff <= nxt_duty_buf;
      else if (overflow)
        duty_act_ff <= duty_buf_ff;
    end
  end

  assign o_prdata                  = prdata_ff;
  assign o_pready                  = pready_ff;
  assign o_pslverr                 = pslverr_ff;
  assign o_upper_counter_interrupt = irq_ff;
  assign o_pwm_out_pin             = pin_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_timer_match_clear: assert property (
    cmp_match && mode == CTP_TIMER |=> cnt_ff == RST_WORD && o_upper_counter_interrupt)
    else $error("Timer match did not clear counter and raise interrupt.");

  chk_halt_holds_zero: assert property (
    !run |=> cnt_ff == RST_WORD)
    else $error("Counter moved while halted.");

  chk_event_increment: assert property (
    run && mode == CTP_EVENT && ext_fall && !cmp_match |=> cnt_ff == $past(cnt_ff) + CNT_ONE)
    else $error("Event falling edge not counted.");

  chk_event_quiet: assert property (
    run && mode == CTP_EVENT && !ext_fall |=> cnt_ff == $past(cnt_ff) || $past(upper_wr))
    else $error("Event counter moved without a falling edge.");

  chk_pin_inverse: assert property (
    o_pwm_out_pin == !ff_ff)
    else $error("Pin is not the inverse of the flip-flop.");

  chk_pwm_overflow: assert property (
    overflow |=> cnt_ff == RST_WORD && o_upper_counter_interrupt && ff_ff != $past(ff_ff))
    else $error("Overflow did not toggle, clear and interrupt.");

  chk_duty_toggle: assert property (
    duty_match && !upper_wr |=> ff_ff != $past(ff_ff) && cnt_ff == $past(cnt_plus))
    else $error("Duty match did not toggle the flip-flop.");

  chk_duty_transfer: assert property (
    overflow |=> duty_act_ff == $past(duty_buf_ff))
    else $error("Duty buffer not transferred at interrupt.");

  chk_stop_hold: assert property (
    !run && !upper_wr |=> ff_ff == $past(ff_ff))
    else $error("Flip-flop changed while halted without a write.");

  chk_cmp_immediate: assert property (
    wr_en && hit(i_paddr, ADDR_CMP_LO) |=> cmp_val[7:0] == $past(i_pwdata[7:0]))
    else $error("Compare low byte not effective at once.");

  cov_timer_match: cover property (cmp_match && mode == CTP_TIMER);
  cov_event_match: cover property (cmp_match && mode == CTP_EVENT);
  cov_pwm_period:  cover property (duty_match ##[1:1000] overflow);

endmodule

`default_nettype wire

/* tb/ctp_event_src.sv */
// Behavioural source of falling edges on the external count input.
`timescale 1ns/1ps
`default_nettype none

module ctp_event_src
(
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_pulses,
  input  wire logic [7:0] i_hold,
  output logic            o_line,
  output logic            o_busy
);
  int n;
  int h;

  initial
  begin
    o_line = 1'b1;
    o_busy = 1'b0;
  end

  // ---------------------------------------------------------------
  // Pulse train, each level held for the requested number of cycles, but never fewer than two.
  // ---------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_go === 1'b1 && o_busy === 1'b0)
    begin
      o_busy <= 1'b1;
      n = i_pulses;
      h = (i_hold < 8'h02) ? 2 : int'(i_hold);
      repeat (n)
      begin
        o_line <= 1'b0;
        repeat (h) @(posedge i_clk);
        o_line <= 1'b1;
        repeat (h) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/ctp_timer16_bench.sv */
// Self-checking bench for the cascaded 16-bit timer, event counter and PWM unit.
`timescale 1ns/1ps
`default_nettype none

module ctp_timer16_bench;
  import ctp_pkg::*;
  logic        i_clk;
  logic        i_rst;
  logic        psel, penable, pwrite, fs_tick, low_speed, ev_go, ev_busy, ev_line;
  logic [7:0]  paddr, ev_n, ev_hold;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, pin;
  logic [32:0] exp_q[$];
  logic [1:0]  fs_cnt;
  logic [15:0] cmp, duty, duty2;
  int          error_cnt, n_tests, irq_cnt, n;
  logic [2:0]  tap_clk[7] = '{CLK_FC_DIV3, CLK_FC_DIV5, CLK_FC_DIV7, CLK_SLOWEST,
                              CLK_SLOWEST, CLK_SLOWEST, CLK_FC_DIV3};
  int          tap_div[7] = '{8, 32, 128, 2048, 32, 32, 8};
  logic        tap_dv[7]  = '{0, 0, 0, 0, 1, 0, 0};
  logic        tap_ls[7]  = '{0, 0, 0, 0, 0, 1, 0};

  ctp_timer16 u_ctp_timer16 (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_fs_tick(fs_tick),
    .i_low_speed(low_speed), .i_external_count_input(ev_line), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_upper_counter_interrupt(irq),
    .o_pwm_out_pin(pin));
  ctp_event_src u_ctp_event_src (.i_clk(i_clk), .i_go(ev_go), .i_pulses(ev_n),
    .i_hold(ev_hold), .o_line(ev_line), .o_busy(ev_busy));

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // Low-frequency tick and read-back monitor.
  // ---------------------------------------------------------------
  always @(posedge i_clk)
  begin
    fs_cnt <= fs_cnt + 2'h1;
    fs_tick <= (fs_cnt == 2'h3);
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      chk(exp_q.pop_front(), {pslverr, prdata});
  end

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic set16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask

  task automatic uc(input logic ff, input logic run, input logic dv);
    wr(ADDR_UPPER_CTRL, {ff, 3'h0, run, 2'h0, dv});
  endtask

  task automatic wait_irq(input int bound, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge i_clk);
      cyc++;
    end
    while (irq !== 1'b1 && cyc < bound);
    if (irq !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic pulses(input logic [7:0] cnt, input logic [7:0] hold);
    int k;
    @(posedge i_clk);
    ev_go <= 1'b1;
    ev_n <= cnt;
    ev_hold <= hold;
    @(posedge i_clk);
    ev_go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (ev_busy === 1'b1 && k < 4000);
    if (ev_busy === 1'b1)
    begin
      error_cnt++;
      summarize();
    end
    repeat (3) @(posedge i_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, fs_tick, low_speed, ev_go} = 6'h00;
    {paddr, ev_n, ev_hold, fs_cnt} = 26'h000_0000;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    n_tests = 0;
    irq_cnt = 0;
    i_rst = 1'b1;
    void'($urandom(32'hc80a));
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 0; a <= 24; a += 4) rd(a[7:0], 32'h0000_0000, 1'b0);
    rd(8'h1C, 32'h0000_0000, 1'b1);
    chk(33'h1, {32'h0000_0000, pin});
    wr(ADDR_LOWER_CTRL, {1'b0, CLK_FC_DIV3, 1'b0, MODE_TIMER16});
    set16(ADDR_CMP_LO, 16'h0002);
    repeat (40) @(posedge i_clk);
    rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      cmp = (i == 6) ? {8'h01, 8'($urandom)} : 16'h0002;
      uc(1'b0, 1'b0, 1'b0);
      low_speed <= tap_ls[i];
      wr(ADDR_LOWER_CTRL, {1'b0, tap_clk[i], 1'b0, MODE_TIMER16});
      set16(ADDR_CMP_LO, cmp);
      uc(1'b0, 1'b1, tap_dv[i]);
      wait_irq(10000, n);
      wait_irq(10000, n);
      chk(33'(cmp * tap_div[i]), 33'(n));
    end
    uc(1'b0, 1'b0, 1'b0);
    low_speed <= 1'b0;
    wr(ADDR_LOWER_CTRL, {4'h0, 1'b0, MODE_EVENT16});
    set16(ADDR_CMP_LO, 16'h0005);
    uc(1'b0, 1'b1, 1'b0);
    n = irq_cnt;
    pulses(8'h04, 8'h02);
    rd(ADDR_STATUS, 32'h0002_0004, 1'b0);
    pulses(8'h01, 8'h02);
    chk(33'(n + 1), 33'(irq_cnt));
    rd(ADDR_STATUS, 32'h0002_0000, 1'b0);
    pulses(8'h03, 8'h05);
    rd(ADDR_STATUS, 32'h0002_0003, 1'b0);
    uc(1'b0, 1'b0, 1'b0);
    wr(ADDR_LOWER_CTRL, {1'b0, CLK_FC, 1'b0, MODE_PWM16});
    duty = {8'h80, 8'($urandom)};
    duty2 = duty ^ 16'h0101;
    set16(ADDR_DUTY_LO, duty);
    rd(ADDR_DUTY_HI, {24'h00_0000, duty[15:8]}, 1'b0);
    uc(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge i_clk);
    chk(33'h0, {32'h0000_0000, pin});
    uc(1'b1, 1'b1, 1'b0);
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pin !== 1'b1 && n < 40000);
    if (pin !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
    chk(33'h1, {32'h0, (n + 3 >= int'(duty)) && (n <= int'(duty) + 3)});
    set16(ADDR_DUTY_LO, duty2);
    rd(ADDR_DUTY_HI, {24'h00_0000, duty[15:8]}, 1'b0);
    wait_irq(70000, n);
    chk(33'h0, {32'h0000_0000, pin});
    rd(ADDR_DUTY_HI, {24'h00_0000, duty2[15:8]}, 1'b0);
    uc(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge i_clk);
    chk(33'h0, {32'h0000_0000, pin});
    rd(ADDR_STATUS, 32'h0001_0000, 1'b0);
    uc(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge i_clk);
    chk(33'h1, {32'h0000_0000, pin});
    wr(ADDR_LOWER_CTRL, {1'b0, CLK_EXTERNAL, 1'b0, MODE_PWM16});
    uc(1'b0, 1'b1, 1'b0);
    pulses(8'h03, 8'h02);
    rd(ADDR_STATUS, 32'h0002_0003, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
